//--- rtl/ssr_pkg.sv
// Constants and types of the status summary reporting block
// Function
// - Each status source has its own enable mask
// - Summary bit is OR of source AND mask
// - Service request mask gates the status byte
// - Pending request appends marker to next response
// - Status byte read clears its latched summary bits
// - Questionable register read clears it
// - Queue read removes entry; empty gives code zero
// - Latched enabled temperature fault with a message queued reads eighty-eight
// - Temperature fault alone reads thirty-two
// - Message-available bit high while queue non-empty
// - Request-service bit set by any enabled bit
// - Queue keeps ten most recent entries
package ssr_pkg;

  // Widths
  localparam int OPER_W = 16;
  localparam int EVENT_W = 8;
  localparam int QUES_W = 16;
  localparam int STB_W = 8;
  localparam int CODE_W = 16;

  // Queue depth and pointer widths
  localparam int QUEUE_DEPTH = 10;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] QUEUE_LAST = 4'h9;
  localparam logic [PTR_W-1:0] QUEUE_FULL = 4'ha;

  // Status byte field positions
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_OPER_BIT = 7;

  // Questionable register field positions
  localparam int TEMPERATURE_FAULT_BIT = 5;

  // Values after reset
  localparam logic [OPER_W-1:0] OPER_RESET = 16'h0000;
  localparam logic [EVENT_W-1:0] EVENT_RESET = 8'h00;
  localparam logic [QUES_W-1:0] QUES_RESET = 16'h0000;
  localparam logic [STB_W-1:0] STB_RESET = 8'h00;
  localparam logic [CODE_W-1:0] NO_ERROR_CODE = 16'h0000;

  // Marker appended to a response, sent by the text channel
  localparam logic [47:0] RQS_MARKER = 48'h3b_21_52_51_53_21;

  typedef logic [CODE_W-1:0] ssr_code_t;

endpackage : ssr_pkg

//--- rtl/ssr_event_queue.sv
// Error and event message queue holding the latest entries
`timescale 1ns/1ps
module ssr_event_queue (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Producer side
  input wire logic i_push,
  input wire ssr_pkg::ssr_code_t i_push_code,
  // Consumer side
  input wire logic i_pop,
  output ssr_pkg::ssr_code_t o_head_code,
  output logic o_empty
);
  import ssr_pkg::*;

  ssr_code_t mem_reg [QUEUE_DEPTH];
  ssr_code_t mem_next [QUEUE_DEPTH];
  logic [PTR_W-1:0] head_reg, head_next;
  logic [PTR_W-1:0] count_reg, count_next;
  logic [PTR_W-1:0] tail;

  function automatic logic [PTR_W-1:0] wrap_add(
    input logic [PTR_W-1:0] p, input logic [PTR_W-1:0] n);
    logic [PTR_W:0] s;
    s = {1'b0, p} + {1'b0, n};
    if (s > {1'b0, QUEUE_LAST}) begin
      s = s - {1'b0, QUEUE_FULL};
    end
    return s[PTR_W-1:0];
  endfunction : wrap_add

  assign tail = wrap_add(head_reg, count_reg);
  assign o_empty = (count_reg == '0);
  assign o_head_code = o_empty ? NO_ERROR_CODE : mem_reg[head_reg];

  always_comb begin
    mem_next = mem_reg;
    head_next = head_reg;
    count_next = count_reg;
    if (i_push) begin
      // When full the tail lands on the oldest entry
      mem_next[tail] = i_push_code;
    end
    if (i_push && count_reg == QUEUE_FULL) begin
      head_next = wrap_add(head_reg, 4'h1);
    end else if (i_pop && !o_empty) begin
      head_next = wrap_add(head_reg, 4'h1);
      if (!i_push) begin
        count_next = count_reg - 4'h1;
      end
    end else if (i_push) begin
      count_next = count_reg + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      head_reg <= '0;
      count_reg <= '0;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        mem_reg[i] <= NO_ERROR_CODE;
      end
    end else if (i_ce) begin
      head_reg <= head_next;
      count_reg <= count_next;
      mem_reg <= mem_next;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  queue_depth_a: assert property (count_reg <= QUEUE_FULL)
    else $error("queue holds more than ten entries");
  queue_pop_a: assert property (
    i_ce && i_pop && !i_push && !o_empty |=>
      count_reg == $past(count_reg) - 4'h1)
    else $error("queue read did not remove an entry");

endmodule : ssr_event_queue

//--- rtl/ssr_top.sv
// Status summary reporting: registers, masks, status byte and request
`timescale 1ns/1ps
module ssr_top (
  // Clock, reset, enable
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  // Status sources
  input wire logic [ssr_pkg::OPER_W-1:0] I_OPER_STATE,
  input wire logic [ssr_pkg::EVENT_W-1:0] I_EVENT_SET,
  input wire logic [ssr_pkg::QUES_W-1:0] I_QUES_SET,
  // Mask writes
  input wire logic [ssr_pkg::QUES_W-1:0] I_MASK_WDATA,
  input wire logic I_OPER_MASK_WE,
  input wire logic I_EVENT_MASK_WE,
  input wire logic I_QUES_MASK_WE,
  input wire logic I_SRQ_MASK_WE,
  // Mask readback
  output logic [ssr_pkg::OPER_W-1:0] O_OPER_MASK,
  output logic [ssr_pkg::EVENT_W-1:0] O_EVENT_MASK,
  output logic [ssr_pkg::QUES_W-1:0] O_QUES_MASK,
  output logic [ssr_pkg::STB_W-1:0] O_SRQ_MASK,
  // Status reads
  input wire logic I_STB_RD,
  input wire logic I_EVENT_RD,
  input wire logic I_QUES_RD,
  input wire logic I_OPER_RD,
  output logic [ssr_pkg::STB_W-1:0] O_STB_DATA,
  output logic [ssr_pkg::EVENT_W-1:0] O_EVENT_DATA,
  output logic [ssr_pkg::QUES_W-1:0] O_QUES_DATA,
  output logic [ssr_pkg::OPER_W-1:0] O_OPER_DATA,
  // Error and event queue
  input wire logic I_ERR_PUSH,
  input wire ssr_pkg::ssr_code_t I_ERR_CODE,
  input wire logic I_ERR_RD,
  output ssr_pkg::ssr_code_t O_ERR_CODE,
  // Response channel
  input wire logic I_RESP_END,
  output logic O_APPEND_MARK,
  output logic O_SRQ
);
  import ssr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Masks

  logic [OPER_W-1:0] operation_state_mask, oper_mask_next;
  logic [EVENT_W-1:0] event_mask_reg, event_mask_next;
  logic [QUES_W-1:0] questionable_status_mask, ques_mask_next;
  logic [STB_W-1:0] srq_mask_reg, srq_mask_next;

  always_comb begin
    oper_mask_next = operation_state_mask;
    event_mask_next = event_mask_reg;
    ques_mask_next = questionable_status_mask;
    srq_mask_next = srq_mask_reg;
    // Status reads never touch the masks
    if (I_OPER_MASK_WE) oper_mask_next = I_MASK_WDATA;
    if (I_EVENT_MASK_WE) event_mask_next = I_MASK_WDATA[EVENT_W-1:0];
    if (I_QUES_MASK_WE) ques_mask_next = I_MASK_WDATA;
    if (I_SRQ_MASK_WE) srq_mask_next = I_MASK_WDATA[STB_W-1:0];
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      operation_state_mask <= OPER_RESET;
      event_mask_reg <= EVENT_RESET;
      questionable_status_mask <= QUES_RESET;
      srq_mask_reg <= STB_RESET;
    end else if (I_CE) begin
      operation_state_mask <= oper_mask_next;
      event_mask_reg <= event_mask_next;
      questionable_status_mask <= ques_mask_next;
      srq_mask_reg <= srq_mask_next;
    end
  end

  assign O_OPER_MASK = operation_state_mask;
  assign O_EVENT_MASK = event_mask_reg;
  assign O_QUES_MASK = questionable_status_mask;
  assign O_SRQ_MASK = srq_mask_reg;

  ////////////////////////////////////////////////////////////////////////
  // Source registers

  logic [OPER_W-1:0] operation_state_reg, oper_state_next;
  logic [EVENT_W-1:0] event_status_reg, event_status_next;
  logic [QUES_W-1:0] questionable_status_reg, ques_status_next;

  always_comb begin
    oper_state_next = I_OPER_STATE;
    event_status_next = event_status_reg;
    ques_status_next = questionable_status_reg;
    // New events win over a clearing read
    if (I_EVENT_RD) event_status_next = '0;
    if (I_QUES_RD) ques_status_next = '0;
    event_status_next = event_status_next | I_EVENT_SET;
    ques_status_next = ques_status_next | I_QUES_SET;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      operation_state_reg <= OPER_RESET;
      event_status_reg <= EVENT_RESET;
      questionable_status_reg <= QUES_RESET;
    end else if (I_CE) begin
      operation_state_reg <= oper_state_next;
      event_status_reg <= event_status_next;
      questionable_status_reg <= ques_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status byte and service request

  logic queue_empty;
  ssr_code_t queue_head;
  logic oper_sum, esb_sum, ques_sum, rqs;
  logic [2:0] sum_prev_reg, sum_prev_next;
  logic [STB_W-1:0] stb_sticky_reg, stb_sticky_next;
  logic [STB_W-1:0] stb_low, status_byte;
  logic rqs_prev_reg, rqs_prev_next;
  logic pending_reg, pending_next;

  function automatic logic masked_any(
    input logic [QUES_W-1:0] v, input logic [QUES_W-1:0] m);
    return |(v & m);
  endfunction : masked_any

  assign oper_sum = masked_any(operation_state_reg,
    operation_state_mask);
  assign esb_sum = masked_any({8'h00, event_status_reg},
    {8'h00, event_mask_reg});
  assign ques_sum = masked_any(questionable_status_reg,
    questionable_status_mask);

  // Message-available follows the queue live
  always_comb begin
    stb_low = stb_sticky_reg;
    stb_low[STB_RQS_BIT] = 1'b0;
    stb_low[STB_MAV_BIT] = !queue_empty;
  end

  assign rqs = masked_any({8'h00, stb_low}, {8'h00, srq_mask_reg});

  always_comb begin
    status_byte = stb_low;
    status_byte[STB_RQS_BIT] = rqs;
  end

  always_comb begin
    sum_prev_next = {oper_sum, esb_sum, ques_sum};
    stb_sticky_next = stb_sticky_reg;
    if (I_STB_RD) stb_sticky_next = '0;
    // A summary bit latches on its rising edge, winning over the read
    if (oper_sum && !sum_prev_reg[2]) stb_sticky_next[STB_OPER_BIT] = 1'b1;
    if (esb_sum && !sum_prev_reg[1]) stb_sticky_next[STB_ESB_BIT] = 1'b1;
    if (ques_sum && !sum_prev_reg[0]) stb_sticky_next[STB_QUES_BIT] = 1'b1;
    rqs_prev_next = rqs;
    pending_next = pending_reg;
    if (I_RESP_END) pending_next = 1'b0;
    if (rqs && !rqs_prev_reg) pending_next = 1'b1;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sum_prev_reg <= 3'h0;
      stb_sticky_reg <= STB_RESET;
      rqs_prev_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else if (I_CE) begin
      sum_prev_reg <= sum_prev_next;
      stb_sticky_reg <= stb_sticky_next;
      rqs_prev_reg <= rqs_prev_next;
      pending_reg <= pending_next;
    end
  end

  assign O_APPEND_MARK = pending_reg;
  assign O_SRQ = rqs_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read data

  logic [STB_W-1:0] stb_data_reg, stb_data_next;
  logic [EVENT_W-1:0] event_data_reg, event_data_next;
  logic [QUES_W-1:0] ques_data_reg, ques_data_next;
  logic [OPER_W-1:0] oper_data_reg, oper_data_next;
  ssr_code_t err_code_reg, err_code_next;

  ssr_event_queue u_queue (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_push(I_ERR_PUSH),
    .i_push_code(I_ERR_CODE),
    .i_pop(I_ERR_RD),
    .o_head_code(queue_head),
    .o_empty(queue_empty)
  );

  always_comb begin
    stb_data_next = stb_data_reg;
    event_data_next = event_data_reg;
    ques_data_next = ques_data_reg;
    oper_data_next = oper_data_reg;
    err_code_next = err_code_reg;
    if (I_STB_RD) stb_data_next = status_byte;
    if (I_EVENT_RD) event_data_next = event_status_reg;
    if (I_QUES_RD) ques_data_next = questionable_status_reg;
    if (I_OPER_RD) oper_data_next = operation_state_reg;
    if (I_ERR_RD) err_code_next = queue_head;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      stb_data_reg <= STB_RESET;
      event_data_reg <= EVENT_RESET;
      ques_data_reg <= QUES_RESET;
      oper_data_reg <= OPER_RESET;
      err_code_reg <= NO_ERROR_CODE;
    end else if (I_CE) begin
      stb_data_reg <= stb_data_next;
      event_data_reg <= event_data_next;
      ques_data_reg <= ques_data_next;
      oper_data_reg <= oper_data_next;
      err_code_reg <= err_code_next;
    end
  end

  assign O_STB_DATA = stb_data_reg;
  assign O_EVENT_DATA = event_data_reg;
  assign O_QUES_DATA = ques_data_reg;
  assign O_OPER_DATA = oper_data_reg;
  assign O_ERR_CODE = err_code_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence temp_fault_s;
    I_CE && I_QUES_SET[TEMPERATURE_FAULT_BIT] && !ques_sum &&
      !sum_prev_reg[0] && questionable_status_mask[TEMPERATURE_FAULT_BIT] &&
      srq_mask_reg[STB_QUES_BIT] && !I_QUES_MASK_WE && !I_SRQ_MASK_WE;
  endsequence
  sequence quiet_s;
    I_CE && !I_RESP_END && !I_QUES_MASK_WE && !I_SRQ_MASK_WE;
  endsequence

  marker_after_fault_a: assert property (
    temp_fault_s ##1 (quiet_s and !status_byte[STB_RQS_BIT]) ##1 quiet_s
      |=> O_APPEND_MARK)
    else $error("marker not pending after enabled fault");
  stb_read_clear_a: assert property (
    I_CE && I_STB_RD && !oper_sum && !esb_sum && !ques_sum ##1
      (!oper_sum && !esb_sum && !ques_sum) |->
      stb_sticky_reg == STB_RESET ##1 stb_sticky_reg == STB_RESET)
    else $error("status byte not cleared by read");
  ques_read_clear_a: assert property (
    I_CE && I_QUES_RD && I_QUES_SET == '0 |=>
      questionable_status_reg == QUES_RESET)
    else $error("questionable register not cleared by read");
  empty_read_a: assert property (
    I_CE && I_ERR_RD && queue_empty |=> O_ERR_CODE == NO_ERROR_CODE)
    else $error("empty queue read not no-error");
  value_88_a: assert property (
    stb_sticky_reg[STB_QUES_BIT] && !stb_sticky_reg[STB_ESB_BIT] &&
      !stb_sticky_reg[STB_OPER_BIT] && !queue_empty &&
      srq_mask_reg == 8'h08 && I_CE && I_STB_RD |=> O_STB_DATA == 8'h58)
    else $error("status byte not 88 with fault enabled");
  temp_read_a: assert property (
    I_CE && I_QUES_RD && questionable_status_reg == 16'h0020 |=>
      O_QUES_DATA == 16'h0020)
    else $error("temperature fault not read as 32");
  mav_level_a: assert property (
    I_CE && I_ERR_PUSH |=> status_byte[STB_MAV_BIT])
    else $error("message-available low with entry queued");
  oper_summary_a: assert property (
    I_CE && oper_sum && !sum_prev_reg[2] |=> stb_sticky_reg[STB_OPER_BIT])
    else $error("operation summary not latched");
  rqs_gate_a: assert property (
    I_CE && I_ERR_PUSH && srq_mask_reg[STB_MAV_BIT] && !I_SRQ_MASK_WE
      |=> status_byte[STB_RQS_BIT])
    else $error("request-service bit not set");
  mask_hold_a: assert property (
    I_CE && (I_QUES_RD || I_STB_RD) && !I_QUES_MASK_WE && !I_SRQ_MASK_WE
      |=> $stable(questionable_status_mask) && $stable(srq_mask_reg))
    else $error("mask changed on status read");

endmodule : ssr_top

//--- verif/ssr_host.sv
// Host model: ends text responses and notes whether the marker rode along
`timescale 1ns/1ps
module ssr_host (
  // Clock
  input wire logic i_clk,
  // Bench control
  input wire logic i_req,
  input wire logic [3:0] i_dly,
  output logic o_marked,
  output logic o_done,
  // Response channel
  input wire logic i_mark,
  output logic o_resp_end
);
  initial begin
    o_resp_end = 1'b0;
    o_marked = 1'b0;
    o_done = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Delay lets outputs settle after the falling edge before use
  always begin
    @(negedge i_clk);
    #1;
    if (i_req && !o_done) begin
      repeat (i_dly) @(negedge i_clk);
      #1;
      o_marked = i_mark;
      o_resp_end = 1'b1;
      @(negedge i_clk);
      #1;
      o_resp_end = 1'b0;
      o_done = 1'b1;
    end else if (!i_req) begin
      o_done = 1'b0;
    end
  end
endmodule : ssr_host

//--- verif/tb.sv
// Self-checking bench of the status summary block
`timescale 1ns/1ps
module tb;
  import ssr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [15:0] oper_st = 16'h0000, ques_set = 16'h0000;
  logic [15:0] wdata = 16'h0000, ecode = 16'h0000;
  logic [7:0] ev_set = 8'h00;
  logic [3:0] we = 4'h0, rd = 4'h0, dly = 4'h0;
  logic epush = 1'b0, erd = 1'b0, req = 1'b0;
  logic [15:0] om, qm, od, qd;
  ssr_code_t eco;
  logic [7:0] em, sm, sd, ed;
  logic rend, amark, srq, marked, hdone;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  ssr_top DUT (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce),
    .I_OPER_STATE(oper_st), .I_EVENT_SET(ev_set), .I_QUES_SET(ques_set),
    .I_MASK_WDATA(wdata), .I_OPER_MASK_WE(we[0]),
    .I_EVENT_MASK_WE(we[1]), .I_QUES_MASK_WE(we[2]),
    .I_SRQ_MASK_WE(we[3]), .O_OPER_MASK(om), .O_EVENT_MASK(em),
    .O_QUES_MASK(qm), .O_SRQ_MASK(sm), .I_STB_RD(rd[3]),
    .I_EVENT_RD(rd[1]), .I_QUES_RD(rd[2]), .I_OPER_RD(rd[0]),
    .O_STB_DATA(sd), .O_EVENT_DATA(ed), .O_QUES_DATA(qd),
    .O_OPER_DATA(od), .I_ERR_PUSH(epush), .I_ERR_CODE(ecode),
    .I_ERR_RD(erd), .O_ERR_CODE(eco), .I_RESP_END(rend),
    .O_APPEND_MARK(amark), .O_SRQ(srq));
  ssr_host HOST (.i_clk(clk), .i_req(req), .i_dly(dly),
    .o_marked(marked), .o_done(hdone), .i_mark(amark),
    .o_resp_end(rend));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  // Index 0 operation, 1 event, 2 questionable, 3 service request
  task automatic wr(input int k, input logic [15:0] d);
    @(negedge clk);
    wdata = d;
    we[k] = 1'b1;
    @(negedge clk);
    we = 4'h0;
  endtask : wr
  // Index 0 operation, 1 event, 2 questionable, 3 status byte
  task automatic chkr(input int k, input logic [15:0] e);
    logic [15:0] v;
    @(negedge clk);
    rd[k] = 1'b1;
    @(negedge clk);
    rd = 4'h0;
    case (k)
      0: v = od;
      1: v = {8'h00, ed};
      2: v = qd;
      default: v = {8'h00, sd};
    endcase
    chk(v, e);
  endtask : chkr
  task automatic push(input logic [15:0] c);
    @(negedge clk);
    epush = 1'b1;
    ecode = c;
    @(negedge clk);
    epush = 1'b0;
  endtask : push
  task automatic pop(input logic [15:0] e);
    @(negedge clk);
    erd = 1'b1;
    @(negedge clk);
    erd = 1'b0;
    chk(eco, e);
  endtask : pop
  task automatic resp(input logic [3:0] d, input logic e);
    int n;
    @(negedge clk);
    dly = d;
    req = 1'b1;
    for (n = 0; n < 40 && hdone !== 1'b1; n++) @(negedge clk);
    req = 1'b0;
    chk({15'h0000, marked}, {15'h0000, e});
  endtask : resp
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(om, 16'h0000);
    chk({em, sm}, 16'h0000);
    chk(qm, 16'h0000);
    chkr(3, 16'h0000);
    pop(16'h0000);
  endtask : t_reset
  task automatic t_masks();
    for (int k = 0; k < 4; k++) wr(k, 16'ha5c3);
    chk(om, 16'ha5c3);
    chk(qm, 16'ha5c3);
    chk({em, sm}, 16'hc3c3);
    for (int k = 0; k < 4; k++) wr(k, 16'h0000);
    // Clock enable low freezes the masks
    ce = 1'b0;
    wr(2, 16'hffff);
    chk(qm, 16'h0000);
    ce = 1'b1;
  endtask : t_masks
  task automatic t_fault();
    wr(2, 16'h0020);
    wr(3, 16'h0008);
    push(16'hff06);
    @(negedge clk);
    ques_set = 16'h0020;
    @(negedge clk);
    ques_set = 16'h0000;
    wait_n(4);
    chk({15'h0000, srq}, 16'h0001);
    resp(4'h3, 1'b1);
    chkr(3, 16'h0058);
    chkr(2, 16'h0020);
    pop(16'hff06);
    chkr(3, 16'h0000);
    chkr(2, 16'h0000);
    pop(16'h0000);
    chk(qm, 16'h0020);
    chk({8'h00, sm}, 16'h0008);
    resp(4'h0, 1'b0);
  endtask : t_fault
  task automatic t_oper();
    wr(3, 16'h0000);
    oper_st = 16'h084b;
    wr(0, 16'h0030);
    wait_n(3);
    chkr(3, 16'h0000);
    wr(0, 16'h0039);
    wait_n(3);
    chkr(3, 16'h0080);
    chkr(3, 16'h0000);
    chkr(0, 16'h084b);
    oper_st = 16'h0000;
    wr(0, 16'h0030);
    oper_st = 16'h0855;
    wait_n(3);
    chkr(3, 16'h0080);
  endtask : t_oper
  task automatic t_event();
    wr(1, 16'h0001);
    wr(3, 16'h0020);
    @(negedge clk);
    ev_set = 8'h81;
    @(negedge clk);
    ev_set = 8'h00;
    wait_n(4);
    chk({15'h0000, srq}, 16'h0001);
    resp(4'h5, 1'b1);
    chkr(1, 16'h0081);
    chkr(1, 16'h0000);
    chkr(3, 16'h0060);
    chkr(3, 16'h0000);
    wr(3, 16'h0000);
  endtask : t_event
  task automatic t_queue();
    wr(3, 16'h0010);
    for (int i = 1; i < 12; i++) push(16'(i));
    chk({15'h0000, srq}, 16'h0001);
    resp(4'h2, 1'b1);
    for (int i = 2; i < 12; i++) pop(16'(i));
    pop(16'h0000);
    chk({15'h0000, srq}, 16'h0000);
    wr(3, 16'h0000);
  endtask : t_queue
  ////////////////////////////////////////////////////////////////////////
  initial begin
    wait_n(8);
    rst = 1'b0;
    t_reset();
    t_masks();
    t_fault();
    t_oper();
    t_event();
    t_queue();
    end_sim();
  end
endmodule : tb
